// ### verilog/btt_pkg.sv
// Package for the buffer transfer timing select block: offsets, fields, reset values, carriers.
// Assumes a single 40 MHz system clock and an AHB-Lite register bus with 32-bit data.
package btt_pkg;
  localparam int unsigned NUM_CH           = 3;
  // Register byte offsets, one aligned word each
  localparam logic [11:0] OFS_SEL_CH0      = 12'h000;
  localparam logic [11:0] OFS_SEL_CH3      = 12'h004;
  localparam logic [11:0] OFS_SEL_CH4      = 12'h008;
  localparam logic [11:0] OFS_STATUS       = 12'h00c;
  // Field positions
  localparam int unsigned BIT_PAIR_A       = 0;
  localparam int unsigned BIT_PAIR_B       = 1;
  localparam int unsigned BIT_PAIR_E       = 2;
  // Writable masks per channel instance
  localparam logic [7:0]  MASK_CH0         = 8'h07;
  localparam logic [7:0]  MASK_CH34        = 8'h03;
  localparam logic [7:0]  RST_SEL          = 8'h00;
  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;
  localparam logic [1:0]  HTRANS_IDLE      = 2'h0;
  // Bus answer after reset: ready, OKAY
  localparam logic        RST_READYOUT     = 1'h1;
  localparam logic        RESP_OKAY        = 1'h0;

  // Timing strobes from one timer channel
  typedef struct packed {
    logic cmp_a;
    logic cmp_b;
    logic cmp_e;
    logic cnt_clr;
    logic buf_en_a;
    logic buf_en_b;
    logic buf_en_e;
  } btt_chan_in_t;

  // Copy strobes back to one timer channel
  typedef struct packed {
    logic copy_a;
    logic copy_b;
    logic copy_e;
  } btt_chan_out_t;

  typedef enum logic { ST_IDLE, ST_DATA } btt_phase_t;
endpackage

// ### verilog/btt_top.sv
// Buffer transfer timing select registers for timer channels 0, 3 and 4, with copy strobe generation.
// Assumes single-cycle strobes from the timer channels on i_clk_sys and one AHB-Lite master.
// How it works
// R1: three 8-bit read/write timing registers, for channels 0, 3 and 4.
// R2: bits 7..3 read zero; software writes zero there.
// R3: bit 2 picks E-pair copy: compare match E or channel 0 counter clear.
// R4: on channels 3 and 4, bit 2 reads zero and ignores writes.
// R5: software keeps the E select at zero outside PWM mode on channel 0.
// R6: bit 1 picks B-pair copy: compare match B or that channel's counter clear.
// R7: software keeps the B select at zero on channels outside PWM mode.
// R8: bits 2..0 reset to zero; all three are writable on channel 0, bits 1..0 on channels 3 and 4; bits 7..3 stay zero.
// R9: bit 0 picks A-pair copy: compare match A or counter clear.
// R10: a pair copies only while its buffer-operation enable is set.
module btt_top (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst,
  input  wire logic                        i_hsel,
  input  wire logic [31:0]                 i_haddr,
  input  wire logic [1:0]                  i_htrans,
  input  wire logic                        i_hwrite,
  input  wire logic [2:0]                  i_hsize,
  input  wire logic [31:0]                 i_hwdata,
  input  wire logic                        i_hready,
  output logic      [31:0]                 o_hrdata,
  output logic                             o_hreadyout,
  output logic                             o_hresp,
  input  wire btt_pkg::btt_chan_in_t       i_chan [btt_pkg::NUM_CH],
  output btt_pkg::btt_chan_out_t           o_chan [btt_pkg::NUM_CH]
);

  // One packed word holds all state; bus answers and copy strobes leave straight from it
  typedef struct packed {
    btt_pkg::btt_phase_t phase;
    logic                wr;
    logic [11:0]         addr;
    logic [31:0]         rdata;
    logic                readyout;
    logic                resp;
    logic [7:0]          sel_ch0;
    logic [7:0]          sel_ch3;
    logic [7:0]          sel_ch4;
    logic [2:0][2:0]     copy;
    logic [2:0]          copy_seen;
  } btt_state_t;

  btt_state_t      state;
  btt_state_t      next_state;

  // Address phase decode
  logic            addr_take;
  logic [11:0]     addr_word;
  logic            addr_hit_ch0;
  logic            addr_hit_ch3;
  logic            addr_hit_ch4;
  logic            addr_hit_status;
  logic            addr_rd_status;
  logic [31:0]     addr_rdata;

  // Data phase decode
  logic            data_phase;
  logic            data_wr;
  logic            data_wr_ch0;
  logic            data_wr_ch3;
  logic            data_wr_ch4;
  logic [7:0]      data_byte;
  logic [7:0]      data_sel_ch0;
  logic [7:0]      data_sel_ch34;
  logic [7:0]      cur_sel_ch0;
  logic [7:0]      cur_sel_ch3;
  logic [7:0]      cur_sel_ch4;

  // Per-channel copy decision
  logic [2:0][7:0] sel_view;
  logic [2:0]      time_a;
  logic [2:0]      time_b;
  logic [2:0]      time_e;
  logic [2:0]      event_a;
  logic [2:0]      event_b;
  logic [2:0]      event_e;
  logic [2:0][2:0] next_copy;
  logic [2:0]      copy_any;

  // Only the word offset is decoded; the low two address bits are ignored
  assign addr_take       = i_hsel && i_hready && (i_htrans == btt_pkg::HTRANS_NONSEQ);
  assign addr_word       = {i_haddr[11:2], 2'b00};
  assign addr_hit_ch0    = (addr_word == btt_pkg::OFS_SEL_CH0);
  assign addr_hit_ch3    = (addr_word == btt_pkg::OFS_SEL_CH3);
  assign addr_hit_ch4    = (addr_word == btt_pkg::OFS_SEL_CH4);
  assign addr_hit_status = (addr_word == btt_pkg::OFS_STATUS);
  assign addr_rd_status  = addr_take && !i_hwrite && addr_hit_status;

  assign data_phase    = (state.phase == btt_pkg::ST_DATA);
  assign data_wr       = data_phase && state.wr;
  assign data_wr_ch0   = data_wr && (state.addr == btt_pkg::OFS_SEL_CH0);
  assign data_wr_ch3   = data_wr && (state.addr == btt_pkg::OFS_SEL_CH3);
  assign data_wr_ch4   = data_wr && (state.addr == btt_pkg::OFS_SEL_CH4);
  assign data_byte     = i_hwdata[7:0];
  assign data_sel_ch0  = data_byte & btt_pkg::MASK_CH0;   // [R2] [R8]
  assign data_sel_ch34 = data_byte & btt_pkg::MASK_CH34;  // [R2] [R4]

  // A read pipelined behind a write to the same register sees the new value
  assign cur_sel_ch0 = data_wr_ch0 ? data_sel_ch0 : state.sel_ch0;
  assign cur_sel_ch3 = data_wr_ch3 ? data_sel_ch34 : state.sel_ch3;
  assign cur_sel_ch4 = data_wr_ch4 ? data_sel_ch34 : state.sel_ch4;

  // Read data is chosen in the address phase so that it stands from a flip-flop in the data phase
  assign addr_rdata = addr_hit_ch0    ? {24'h000000, cur_sel_ch0} :  // [R1]
                      addr_hit_ch3    ? {24'h000000, cur_sel_ch3} :  // [R1]
                      addr_hit_ch4    ? {24'h000000, cur_sel_ch4} :  // [R1]
                      addr_hit_status ? {29'h0, state.copy_seen}  :
                                        32'h00000000;

  assign sel_view[0] = state.sel_ch0;
  assign sel_view[1] = state.sel_ch3;
  assign sel_view[2] = state.sel_ch4;

  // Channels 3 and 4 have no E timing select: their bit 2 is masked, so E follows compare match only
  genvar g;
  generate
    for (g = 0; g < btt_pkg::NUM_CH; g++) begin : g_ch
      assign time_a[g]       = sel_view[g][btt_pkg::BIT_PAIR_A];                    // [R9]
      assign time_b[g]       = sel_view[g][btt_pkg::BIT_PAIR_B];                    // [R6]
      assign time_e[g]       = sel_view[g][btt_pkg::BIT_PAIR_E];                    // [R3] [R4]
      assign event_a[g]      = time_a[g] ? i_chan[g].cnt_clr : i_chan[g].cmp_a;    // [R9]
      assign event_b[g]      = time_b[g] ? i_chan[g].cnt_clr : i_chan[g].cmp_b;    // [R6]
      assign event_e[g]      = time_e[g] ? i_chan[g].cnt_clr : i_chan[g].cmp_e;    // [R3]
      assign next_copy[g][0] = i_chan[g].buf_en_a && event_a[g];                   // [R10]
      assign next_copy[g][1] = i_chan[g].buf_en_b && event_b[g];                   // [R10]
      assign next_copy[g][2] = i_chan[g].buf_en_e && event_e[g];                   // [R10]
      assign copy_any[g]     = |next_copy[g];
      assign o_chan[g]       = '{copy_a: state.copy[g][0],
                                 copy_b: state.copy[g][1],
                                 copy_e: state.copy[g][2]};
    end
  endgenerate

  always_comb begin
    next_state      = state;
    next_state.copy = next_copy;
    // A write lands at the edge that ends its data phase
    if (data_wr_ch0) begin
      next_state.sel_ch0 = data_sel_ch0;  // [R8]
    end
    if (data_wr_ch3) begin
      next_state.sel_ch3 = data_sel_ch34;  // [R4]
    end
    if (data_wr_ch4) begin
      next_state.sel_ch4 = data_sel_ch34;  // [R4]
    end
    case (state.phase)
      btt_pkg::ST_IDLE: begin
      end
      btt_pkg::ST_DATA: begin
        next_state.phase = btt_pkg::ST_IDLE;
      end
      default: begin
        next_state.phase = btt_pkg::ST_IDLE;
      end
    endcase
    // Cleared at the edge that captures the status word, so a copy in that cycle waits for the next read
    for (int c = 0; c < btt_pkg::NUM_CH; c++) begin
      if (copy_any[c]) begin
        next_state.copy_seen[c] = 1'b1;
      end else if (addr_rd_status) begin
        next_state.copy_seen[c] = 1'b0;
      end
    end
    if (addr_take) begin
      next_state.phase = btt_pkg::ST_DATA;
      next_state.wr    = i_hwrite;
      next_state.addr  = addr_word;
      next_state.rdata = addr_rdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state          <= '0;
      state.phase    <= btt_pkg::ST_IDLE;
      state.readyout <= btt_pkg::RST_READYOUT;
      state.resp     <= btt_pkg::RESP_OKAY;
      state.sel_ch0  <= btt_pkg::RST_SEL;  // [R8]
      state.sel_ch3  <= btt_pkg::RST_SEL;  // [R8]
      state.sel_ch4  <= btt_pkg::RST_SEL;  // [R8]
    end else begin
      state <= next_state;
    end
  end

  // Zero-wait slave, always OKAY; both answers held in flip-flops
  assign o_hrdata    = state.rdata;
  assign o_hreadyout = state.readyout;
  assign o_hresp     = state.resp;

endmodule

// ### tb/btt_monitor.sv
// Checker for the transfer timing block, watching only its top ports.
// Assumes strobes and enables are held low while reset is asserted.
module btt_monitor (
  input wire logic                   i_clk_sys,
  input wire logic                   i_rst,
  input wire logic [31:0]            o_hrdata,
  input wire logic                   o_hreadyout,
  input wire logic                   o_hresp,
  input wire btt_pkg::btt_chan_in_t  i_chan [btt_pkg::NUM_CH],
  input wire btt_pkg::btt_chan_out_t o_chan [btt_pkg::NUM_CH]
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  AST_RSV: assert property (o_hrdata[31:3] == 29'h0) else $error("reserved bits set");
  AST_OKAY: assert property (o_hreadyout && !o_hresp) else $error("bad bus answer");
  AST_RST: assert property ($past(i_rst) |-> o_hrdata == 32'h0 && o_chan[0] == 3'h0)
    else $error("not cleared");
  AST_A: assert property (o_chan[0].copy_a |->
    $past(i_chan[0].buf_en_a && (i_chan[0].cmp_a || i_chan[0].cnt_clr)))
    else $error("stray copy a");
  AST_B: assert property (o_chan[0].copy_b |->
    $past(i_chan[0].buf_en_b && (i_chan[0].cmp_b || i_chan[0].cnt_clr)))
    else $error("stray copy b");
  AST_E: assert property (o_chan[0].copy_e |->
    $past(i_chan[0].buf_en_e && (i_chan[0].cmp_e || i_chan[0].cnt_clr)))
    else $error("stray copy e");
  AST_BB: assert property ($past(i_chan[0].buf_en_b && i_chan[0].cmp_b && i_chan[0].cnt_clr) |->
    o_chan[0].copy_b)
    else $error("missed copy b");
  AST_E3: assert property (o_chan[1].copy_e |-> $past(i_chan[1].cmp_e)) else $error("ch3 e not on compare");
endmodule
bind btt_top btt_monitor btt_monitor_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_chan(i_chan), .o_chan(o_chan));

// ### tb/tb.sv
// Self-checking bench: register access over the bus, copy strobes per select bit.
// Assumes the zero-wait bus slave and one-cycle copy latency of the block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk = 0, rst = 1, hs = 0, hw = 0, hro, hrsp;
  logic [31:0]            ha = '0, hd = '0, hrd, r;
  logic [1:0]             ht = '0;
  logic [2:0]             hz = '0;
  btt_pkg::btt_chan_in_t  ich [btt_pkg::NUM_CH] = '{default: '0};
  btt_pkg::btt_chan_out_t och [btt_pkg::NUM_CH];
  int                     n_errors = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  btt_top btt_top_i (.i_clk_sys(clk), .i_rst(rst), .i_hsel(hs), .i_haddr(ha), .i_htrans(ht), .i_hwrite(hw),
    .i_hsize(hz), .i_hwdata(hd), .i_hready(hro), .o_hrdata(hrd), .o_hreadyout(hro),
    .o_hresp(hrsp), .i_chan(ich), .o_chan(och));
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One single word transfer; each phase held until ready is sampled high, bounded
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    hs <= 1'b1;
    ha <= {20'h0, a};
    ht <= btt_pkg::HTRANS_NONSEQ;
    hw <= w;
    hz <= btt_pkg::HSIZE_WORD;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hro !== 1'b1 && k < 9);
    if (hro !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t address phase timeout", $time);
      report_and_stop();
    end
    hs <= 1'b0;
    ht <= btt_pkg::HTRANS_IDLE;
    hd <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hro !== 1'b1 && k < 9);
    if (hro !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t data phase timeout", $time);
      report_and_stop();
    end
    r = hrd;
  endtask
  // Drive one strobe cycle on a channel, check the copy one cycle later
  task automatic st(input int c, input logic [6:0] v, input logic [2:0] e);
    ich[c] <= v;
    @(posedge clk);
    ich[c] <= '0;
    @(negedge clk);
    ck({29'h0, och[c]}, {29'h0, e});
    @(posedge clk);
  endtask
  task automatic t_regs();
    xf(0, btt_pkg::OFS_SEL_CH0, 0); ck(r, 0);
    xf(1, btt_pkg::OFS_SEL_CH0, 32'hff); xf(0, btt_pkg::OFS_SEL_CH0, 0); ck(r, 32'h7);
    xf(1, btt_pkg::OFS_SEL_CH3, 32'hff); xf(0, btt_pkg::OFS_SEL_CH3, 0); ck(r, 32'h3);
    xf(1, btt_pkg::OFS_SEL_CH4, 32'hfe); xf(0, btt_pkg::OFS_SEL_CH4, 0); ck(r, 32'h2);
    xf(0, 12'h010, 0); ck(r, 0);
    $display("regs done");
  endtask
  task automatic t_copy();
    // Software keeps the channel 0 select at zero until it chooses counter-clear timing; channels 3 and 4 keep 3 and 2
    xf(1, btt_pkg::OFS_SEL_CH0, 0);
    st(0, 7'h47, 3'h4); st(0, 7'h0f, 3'h0); st(0, 7'h77, 3'h7);
    xf(1, btt_pkg::OFS_SEL_CH0, 32'h7);
    st(0, 7'h0f, 3'h7); st(0, 7'h77, 3'h0); st(0, 7'h08, 3'h0);
    st(0, 7'h7f, 3'h7);
    st(1, 7'h0f, 3'h6); st(1, 7'h17, 3'h1); st(2, 7'h2a, 3'h2);
    // Status word: one sticky bit per channel, cleared by reading it
    xf(0, btt_pkg::OFS_STATUS, 0); ck(r, 32'h7);
    xf(0, btt_pkg::OFS_STATUS, 0); ck(r, 32'h0);
    $display("copy done");
  endtask
  task automatic t_reset();
    xf(1, btt_pkg::OFS_SEL_CH3, 32'h3);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xf(0, btt_pkg::OFS_SEL_CH3, 0); ck(r, 0);
    $display("reset done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_regs();
    t_copy();
    t_reset();
    report_and_stop();
  end
endmodule
